/* rtl/wg_cfg.svh */
/*
 * Offsets, field positions, reset values and bus codes of the
 * steering and dead-band waveform stage.
 * Assumes it is included by its bare name after the package.
 */
`ifndef WG_CFG_SVH
`define WG_CFG_SVH

// Register byte offsets.
`define WG_OFF_CTRL   8'h00
`define WG_OFF_POL    8'h04
`define WG_OFF_STEER  8'h08
`define WG_OFF_ISRC   8'h0C
`define WG_OFF_CLK    8'h10
`define WG_OFF_DBR    8'h14
`define WG_OFF_DBF    8'h18
`define WG_OFF_STAT   8'h1C
`define WG_OFF_SHUT   8'h20

// Control and steering register fields.
`define WG_EN_BIT     7
`define WG_LD_BIT     6
`define WG_MODE_HI    2
`define WG_OVR_LO     4

// Reset values.
`define WG_RST_MODE   3'h0
`define WG_RST_NIB    4'h0
`define WG_RST_DB     6'h00

// Bus answers.
`define WG_RESP_OKAY  2'h0
`define WG_RESP_ERR   2'h2

`endif

/* rtl/wg_pkg.sv */
/*
 * Types of the steering and dead-band waveform stage.
 * Assumes nothing of its surroundings.
 */
package wg_pkg;

	// Output mode codes.
	typedef enum logic [2:0]
	{
		MODE_ASTEER = 3'h0,
		MODE_SSTEER = 3'h1,
		MODE_FB_FWD = 3'h2,
		MODE_FB_REV = 3'h3,
		MODE_HALF   = 3'h4,
		MODE_PP     = 3'h5
	} mode_t;

	// Software configuration gathered in one word.
	typedef struct packed
	{
		logic       enable;
		logic [2:0] mode;
		logic [3:0] polarity;
		logic [3:0] steer_select;
		logic [3:0] override_level;
		logic [3:0] input_source_select;
		logic       clk_sel;
		logic [3:0] shut_level;
	} wg_cfg_t;

endpackage

/* rtl/steering_deadband_waveform.sv */
/*
 * Output stage of a complementary waveform generator: input selection,
 * steering, polarity and two dead-band counters, behind AXI4-Lite.
 * Assumes all inputs are synchronous to CLK_I and that the fast
 * oscillator tick is a one-cycle pulse made in this clock domain.
 */
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/100ps
`include "wg_cfg.svh"
module steering_deadband_waveform
#(
	parameter int DBW = 6,
	parameter int NSRC = 16
)
(
	// Clock and reset.
	input  wire logic            CLK_I,
	input  wire logic            NRST_I,
	// Write address channel.
	input  wire logic [7:0]      S_AXI_AWADDR_I,
	input  wire logic            S_AXI_AWVALID_I,
	output logic                 S_AXI_AWREADY_O,
	// Write data channel.
	input  wire logic [31:0]     S_AXI_WDATA_I,
	input  wire logic [3:0]      S_AXI_WSTRB_I,
	input  wire logic            S_AXI_WVALID_I,
	output logic                 S_AXI_WREADY_O,
	// Write response channel.
	output logic [1:0]           S_AXI_BRESP_O,
	output logic                 S_AXI_BVALID_O,
	input  wire logic            S_AXI_BREADY_I,
	// Read address channel.
	input  wire logic [7:0]      S_AXI_ARADDR_I,
	input  wire logic            S_AXI_ARVALID_I,
	output logic                 S_AXI_ARREADY_O,
	// Read data channel.
	output logic [31:0]          S_AXI_RDATA_O,
	output logic [1:0]           S_AXI_RRESP_O,
	output logic                 S_AXI_RVALID_O,
	input  wire logic            S_AXI_RREADY_I,
	// Data sources, bit index equals the source code.
	input  wire logic [NSRC-1:0] DATA_SRC_I,
	// Dead-band time base and power state.
	input  wire logic            FAST_OSC_TICK_I,
	input  wire logic            SLEEP_I,
	// Shutdown request from the shutdown logic.
	input  wire logic            SHUTDOWN_I,
	// Outputs A to D in bits 0 to 3.
	output logic [3:0]           OUT_O
);

	wg_pkg::wg_cfg_t cfg_q;          // Software configuration.
	logic [DBW-1:0]  db_buf_q [2];   // Written counts, 0 rise, 1 fall.
	logic [DBW-1:0]  db_act_q [2];   // Counts in use.
	logic            ld_q;           // Load request pending.
	logic            armed_q;        // Falling edge seen since request.
	logic            aw_hold_q;      // Write address captured.
	logic [7:0]      aw_addr_q;      // Captured write address.
	logic            w_hold_q;       // Write data captured.
	logic [31:0]     w_data_q;       // Captured write data.
	logic            w_lane_q;       // Low byte lane enabled.
	logic            bvalid_q;       // Write answer pending.
	logic [1:0]      bresp_q;        // Write answer code.
	logic            rvalid_q;       // Read answer pending.
	logic [1:0]      rresp_q;        // Read answer code.
	logic [31:0]     rdata_q;        // Read answer data.
	logic            in_q;           // Sampled data input.
	logic            in_prev_q;      // Previous sample.
	logic            rise;           // Input rising edge.
	logic            fall;           // Input falling edge.
	logic            tick;           // Dead-band clock period marker.
	logic            dir_q;          // Applied bridge direction, 1 reverse.
	logic            fb;             // A full-bridge mode is set.
	logic            dir_chg;        // Direction change taken now.
	logic [3:0]      steer_sync_q;   // Steering latched at input rise.
	logic [3:0]      steer_eff;      // Steering in force.
	logic [1:0]      start;          // Counter start, 0 rise, 1 fall.
	logic [1:0]      cancel;         // Counter abort.
	logic [1:0]      busy_q;         // Counter running.
	logic [1:0]      done_q;         // Counter finished for this edge.
	logic [DBW-1:0]  cnt_q [2];      // Tick counts.
	logic [3:0]      out_d;          // Next output levels.
	logic [3:0]      out_q;          // Output levels.
	logic            wr_go;          // Write commits this cycle.
	logic            wr_ok;          // Write address is mapped.

	// A write or read address is mapped when it hits a register.
	function automatic logic mapped(input logic [7:0] a);
		logic hit;
		hit = 1'b0;
		case (a)
			`WG_OFF_CTRL, `WG_OFF_POL, `WG_OFF_STEER, `WG_OFF_ISRC,
			`WG_OFF_CLK, `WG_OFF_DBR, `WG_OFF_DBF, `WG_OFF_STAT,
			`WG_OFF_SHUT: hit = 1'b1;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

	// Each address and data channel takes one item while no answer waits.
	assign S_AXI_AWREADY_O = ~aw_hold_q & ~bvalid_q;
	assign S_AXI_WREADY_O  = ~w_hold_q & ~bvalid_q;
	assign S_AXI_BVALID_O  = bvalid_q;
	assign S_AXI_BRESP_O   = bresp_q;
	assign S_AXI_ARREADY_O = ~rvalid_q;
	assign S_AXI_RVALID_O  = rvalid_q;
	assign S_AXI_RRESP_O   = rresp_q;
	assign S_AXI_RDATA_O   = rdata_q;
	assign OUT_O           = out_q;
	assign wr_go           = aw_hold_q & w_hold_q;
	assign wr_ok           = mapped(aw_addr_q);

	// Capture address and data in either order, answer once both are in.
	always_ff @(posedge CLK_I)
	begin
		if (!NRST_I)
		begin
			aw_hold_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_hold_q  <= 1'b0;
			w_data_q  <= 32'h00000000;
			w_lane_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= `WG_RESP_OKAY;
		end
		else
		begin
			if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
			begin
				aw_hold_q <= 1'b1;
				aw_addr_q <= S_AXI_AWADDR_I;
			end
			if (S_AXI_WVALID_I && S_AXI_WREADY_O)
			begin
				w_hold_q <= 1'b1;
				w_data_q <= S_AXI_WDATA_I;
				w_lane_q <= S_AXI_WSTRB_I[0];
			end
			if (wr_go)
			begin
				// Both halves present: commit and answer.
				aw_hold_q <= 1'b0;
				w_hold_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= wr_ok ? `WG_RESP_OKAY : `WG_RESP_ERR;
			end
			else if (bvalid_q && S_AXI_BREADY_I)
			begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// Reads answer one cycle after the address is taken.
	always_ff @(posedge CLK_I)
	begin
		if (!NRST_I)
		begin
			rvalid_q <= 1'b0;
			rresp_q  <= `WG_RESP_OKAY;
			rdata_q  <= 32'h00000000;
		end
		else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O)
		begin
			rvalid_q <= 1'b1;
			rresp_q  <= mapped(S_AXI_ARADDR_I) ? `WG_RESP_OKAY
			                                   : `WG_RESP_ERR;
			rdata_q  <= 32'h00000000;
			case (S_AXI_ARADDR_I)
				`WG_OFF_CTRL:  rdata_q[7:0] <= {cfg_q.enable, ld_q, 3'h0,
				                                cfg_q.mode};
				`WG_OFF_POL:   rdata_q[3:0] <= cfg_q.polarity;
				`WG_OFF_STEER: rdata_q[7:0] <= {cfg_q.override_level,
				                                cfg_q.steer_select};
				`WG_OFF_ISRC:  rdata_q[3:0] <= cfg_q.input_source_select;
				`WG_OFF_CLK:   rdata_q[0]   <= cfg_q.clk_sel;
				`WG_OFF_DBR:   rdata_q[DBW-1:0] <= db_buf_q[0];
				`WG_OFF_DBF:   rdata_q[DBW-1:0] <= db_buf_q[1];
				// Live state: outputs, counters, direction, input.
				`WG_OFF_STAT:  rdata_q[9:0] <= {in_q, dir_q, busy_q,
				                                done_q, out_q};
				`WG_OFF_SHUT:  rdata_q[3:0] <= cfg_q.shut_level;
				default:       rdata_q <= 32'h00000000;
			endcase
		end
		else if (rvalid_q && S_AXI_RREADY_I)
		begin
			rvalid_q <= 1'b0;
		end
	end

	// Configuration registers, written when a mapped write commits.
	always_ff @(posedge CLK_I)
	begin
		if (!NRST_I)
		begin
			cfg_q.enable              <= 1'b0;
			cfg_q.mode                <= `WG_RST_MODE;
			cfg_q.polarity            <= `WG_RST_NIB;
			cfg_q.steer_select        <= `WG_RST_NIB;
			cfg_q.override_level      <= `WG_RST_NIB;
			cfg_q.input_source_select <= `WG_RST_NIB;
			cfg_q.clk_sel             <= 1'b0;
			cfg_q.shut_level          <= `WG_RST_NIB;
		end
		else if (wr_go && w_lane_q)
		begin
			case (aw_addr_q)
				`WG_OFF_CTRL:
				begin
					cfg_q.enable <= w_data_q[`WG_EN_BIT];
					cfg_q.mode   <= w_data_q[`WG_MODE_HI:0];
				end
				`WG_OFF_POL:   cfg_q.polarity <= w_data_q[3:0];
				`WG_OFF_STEER:
				begin
					cfg_q.steer_select   <= w_data_q[3:0];
					cfg_q.override_level <= w_data_q[`WG_OVR_LO+:4];
				end
				`WG_OFF_ISRC:  cfg_q.input_source_select <= w_data_q[3:0];
				`WG_OFF_CLK:   cfg_q.clk_sel <= w_data_q[0];
				`WG_OFF_SHUT:  cfg_q.shut_level <= w_data_q[3:0];
				default:       cfg_q.enable <= cfg_q.enable;
			endcase
		end
	end

	// Dead-band counts: written copy, active copy and load request.
	always_ff @(posedge CLK_I)
	begin
		if (!NRST_I)
		begin
			db_buf_q[0] <= `WG_RST_DB;
			db_buf_q[1] <= `WG_RST_DB;
			db_act_q[0] <= `WG_RST_DB;
			db_act_q[1] <= `WG_RST_DB;
			ld_q        <= 1'b0;
			armed_q     <= 1'b0;
		end
		else
		begin
			if (wr_go && w_lane_q && aw_addr_q == `WG_OFF_DBR)
			begin
				db_buf_q[0] <= w_data_q[DBW-1:0];
				// Disabled: the active copy follows the write at once.
				if (!cfg_q.enable)
					db_act_q[0] <= w_data_q[DBW-1:0];
			end
			if (wr_go && w_lane_q && aw_addr_q == `WG_OFF_DBF)
			begin
				db_buf_q[1] <= w_data_q[DBW-1:0];
				if (!cfg_q.enable)
					db_act_q[1] <= w_data_q[DBW-1:0];
			end
			if (!cfg_q.enable)
			begin
				// Soft reset drops any pending request.
				ld_q    <= 1'b0;
				armed_q <= 1'b0;
			end
			else
			begin
				// A request arms on a falling edge, loads on the next rise.
				if (ld_q && fall)
					armed_q <= 1'b1;
				if (armed_q && rise)
				begin
					db_act_q[0] <= db_buf_q[0];
					db_act_q[1] <= db_buf_q[1];
					armed_q     <= 1'b0;
				end
				// A new request set in the load cycle wins over the clear.
				if (wr_go && w_lane_q && aw_addr_q == `WG_OFF_CTRL &&
				    w_data_q[`WG_LD_BIT])
					ld_q <= 1'b1;
				else if (armed_q && rise)
					ld_q <= 1'b0;
			end
		end
	end

	// Pick the data input and sample it for edge detection.
	always_ff @(posedge CLK_I)
	begin
		if (!NRST_I)
		begin
			in_q      <= 1'b0;
			in_prev_q <= 1'b0;
		end
		else
		begin
			in_q      <= DATA_SRC_I[cfg_q.input_source_select];
			in_prev_q <= in_q;
		end
	end

	assign rise = in_q & ~in_prev_q;
	assign fall = ~in_q & in_prev_q;
	// System clock ticks every cycle unless asleep; oscillator ticks on.
	assign tick = cfg_q.clk_sel ? FAST_OSC_TICK_I : ~SLEEP_I;
	assign fb   = cfg_q.mode[2:1] == 2'h1;
	assign dir_chg = fb & rise & (cfg_q.mode[0] != dir_q);

	// Applied direction changes at an input rise, or follows the mode while disabled.
	always_ff @(posedge CLK_I)
	begin
		if (!NRST_I)
			dir_q <= 1'b0;
		else if (!cfg_q.enable || dir_chg)
			dir_q <= cfg_q.mode[0];
	end

	// Synchronous steering latches the selection at each input rise.
	always_ff @(posedge CLK_I)
	begin
		if (!NRST_I)
			steer_sync_q <= `WG_RST_NIB;
		else if (!cfg_q.enable || rise)
			steer_sync_q <= cfg_q.steer_select;
	end

	// Async steering uses the written value in the cycle after the write.
	assign steer_eff = (cfg_q.mode == wg_pkg::MODE_SSTEER) ? steer_sync_q
	                   : cfg_q.steer_select;

	// Start and abort conditions of the two dead-band counters.
	always_comb
	begin
		start  = 2'h0;
		cancel = 2'h0;
		if (cfg_q.mode == wg_pkg::MODE_HALF)
		begin
			start  = {fall, rise};
			cancel = {rise, fall};
		end
		else if (fb)
		begin
			// Reverse change uses the rise counter, forward the fall one.
			start  = {dir_chg & ~cfg_q.mode[0],
			          dir_chg & cfg_q.mode[0]};
			cancel = {fall, fall};
		end
	end

	// Two counters counting ticks up to the active count.
	for (genvar gi = 0; gi < 2; gi++)
	begin : g_db
		always_ff @(posedge CLK_I)
		begin
			if (!NRST_I)
			begin
				cnt_q[gi]  <= `WG_RST_DB;
				busy_q[gi] <= 1'b0;
				done_q[gi] <= 1'b0;
			end
			else if (!cfg_q.enable)
			begin
				// Idle sides track the input level, so the half bridge
				// shows true and inverted input before the first edge.
				cnt_q[gi]  <= `WG_RST_DB;
				busy_q[gi] <= 1'b0;
				done_q[gi] <= (gi == 0) ? in_q : ~in_q;
			end
			else if (cancel[gi])
			begin
				busy_q[gi] <= 1'b0;
				done_q[gi] <= 1'b0;
			end
			else if (start[gi])
			begin
				cnt_q[gi]  <= `WG_RST_DB;
				busy_q[gi] <= db_act_q[gi] != `WG_RST_DB;
				done_q[gi] <= db_act_q[gi] == `WG_RST_DB;
			end
			else if (busy_q[gi] && tick)
			begin
				// Edge and tick are unrelated, so delay is N-1 to N tick periods.
				cnt_q[gi] <= DBW'(cnt_q[gi] + 1'b1);
				if (DBW'(cnt_q[gi] + 1'b1) == db_act_q[gi])
				begin
					busy_q[gi] <= 1'b0;
					done_q[gi] <= 1'b1;
				end
			end
		end
	end

	// Output levels per mode, before the output flops.
	always_comb
	begin
		logic [3:0] r;
		logic       m;
		r = 4'h0;
		m = 1'b0;
		out_d = 4'h0;
		unique case (wg_pkg::mode_t'(cfg_q.mode))
			wg_pkg::MODE_ASTEER, wg_pkg::MODE_SSTEER:
			begin
				for (int i = 0; i < 4; i++)
				begin
					if (!steer_eff[i])
						out_d[i] = cfg_q.override_level[i];
					else if (SHUTDOWN_I)
						out_d[i] = cfg_q.shut_level[i];
					else
						out_d[i] = in_q ~^ cfg_q.polarity[i];
				end
			end
			wg_pkg::MODE_HALF:
			begin
				r = {done_q[1], done_q[0], done_q[1], done_q[0]};
				out_d = SHUTDOWN_I ? cfg_q.shut_level
				        : (r ~^ cfg_q.polarity);
			end
			wg_pkg::MODE_FB_FWD, wg_pkg::MODE_FB_REV:
			begin
				// Modulated output waits while its counter runs.
				m = in_q & ~busy_q[dir_q ? 0 : 1];
				r = dir_q ? {1'b0, 1'b1, m, 1'b0}
				    : {m, 1'b0, 1'b0, 1'b1};
				out_d = SHUTDOWN_I ? cfg_q.shut_level
				        : (r ~^ cfg_q.polarity);
			end
			wg_pkg::MODE_PP:
			begin
				// Sequencing not built: outputs rest inactive.
				out_d = SHUTDOWN_I ? cfg_q.shut_level
				        : ~cfg_q.polarity;
			end
			default:
			begin
				// Undefined codes rest inactive as well.
				out_d = ~cfg_q.polarity;
			end
		endcase
		if (!cfg_q.enable)
			out_d = 4'h0;
	end

	// Output flops.
	always_ff @(posedge CLK_I)
	begin
		if (!NRST_I)
			out_q <= 4'h0;
		else
			out_q <= out_d;
	end

endmodule

/* test/steering_deadband_waveform_props.sv */
/*
 * Checker of the register bus handshakes and the output reset state.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/100ps
module steering_deadband_waveform_props
#(
	parameter int DBW  = 6,
	parameter int NSRC = 16
)
(
	// Clock and reset.
	input wire logic        CLK_I,
	input wire logic        NRST_I,
	// Write side.
	input wire logic        S_AXI_AWVALID_I,
	input wire logic        S_AXI_AWREADY_O,
	input wire logic        S_AXI_WVALID_I,
	input wire logic        S_AXI_WREADY_O,
	input wire logic [1:0]  S_AXI_BRESP_O,
	input wire logic        S_AXI_BVALID_O,
	input wire logic        S_AXI_BREADY_I,
	// Read side.
	input wire logic        S_AXI_ARVALID_I,
	input wire logic        S_AXI_ARREADY_O,
	input wire logic [31:0] S_AXI_RDATA_O,
	input wire logic        S_AXI_RVALID_O,
	input wire logic        S_AXI_RREADY_I,
	// Outputs A to D.
	input wire logic [3:0]  OUT_O
);
	// All checks run on the one clock and pause in reset.
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!NRST_I);

	// A pending response blocks both write halves.
	property p_aw_block;
		S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O;
	endproperty
	a_aw_block: assert property (p_aw_block)
		else $error("write accepted while a response is pending");

	// Response follows two cycles after both halves are taken together.
	property p_b_after;
		S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I &&
			S_AXI_WREADY_O |=> ##1 S_AXI_BVALID_O;
	endproperty
	a_b_after: assert property (p_b_after)
		else $error("write response late");

	// Response and its code stand until taken.
	property p_b_hold;
		S_AXI_BVALID_O && !S_AXI_BREADY_I |=>
			S_AXI_BVALID_O && $stable(S_AXI_BRESP_O);
	endproperty
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped early");

	// A taken response is gone the next cycle.
	property p_b_drop;
		S_AXI_BVALID_O && S_AXI_BREADY_I |=> !S_AXI_BVALID_O;
	endproperty
	a_b_drop: assert property (p_b_drop)
		else $error("write response repeated");

	// Read address is refused exactly while read data waits.
	property p_ar_ready;
		S_AXI_ARREADY_O == !S_AXI_RVALID_O;
	endproperty
	a_ar_ready: assert property (p_ar_ready)
		else $error("read address ready wrong");

	// Read data arrives one cycle after the address is taken.
	property p_r_after;
		S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O;
	endproperty
	a_r_after: assert property (p_r_after)
		else $error("read data late");

	// Read data stands unchanged until taken.
	property p_r_hold;
		S_AXI_RVALID_O && !S_AXI_RREADY_I |=>
			S_AXI_RVALID_O && $stable(S_AXI_RDATA_O);
	endproperty
	a_r_hold: assert property (p_r_hold)
		else $error("read data changed while waiting");

	// A taken read answer is gone the next cycle.
	property p_r_drop;
		S_AXI_RVALID_O && S_AXI_RREADY_I |=> !S_AXI_RVALID_O;
	endproperty
	a_r_drop: assert property (p_r_drop)
		else $error("read data repeated");

	// The stage comes out of reset disabled with all outputs low.
	property p_rst_out;
		!$past(NRST_I) |-> OUT_O == 4'h0;
	endproperty
	a_rst_out: assert property (p_rst_out)
		else $error("outputs not cleared by reset");

	// Main traffic seen.
	c_err: cover property (S_AXI_BVALID_O && S_AXI_BRESP_O == 2'h2);
	c_read: cover property (S_AXI_RVALID_O && S_AXI_RREADY_I);
	c_all: cover property (OUT_O == 4'hF);
endmodule

bind steering_deadband_waveform steering_deadband_waveform_props
#(
	.DBW  (DBW),
	.NSRC (NSRC)
)
u_props
(
	.CLK_I           (CLK_I),
	.NRST_I          (NRST_I),
	.S_AXI_AWVALID_I (S_AXI_AWVALID_I),
	.S_AXI_AWREADY_O (S_AXI_AWREADY_O),
	.S_AXI_WVALID_I  (S_AXI_WVALID_I),
	.S_AXI_WREADY_O  (S_AXI_WREADY_O),
	.S_AXI_BRESP_O   (S_AXI_BRESP_O),
	.S_AXI_BVALID_O  (S_AXI_BVALID_O),
	.S_AXI_BREADY_I  (S_AXI_BREADY_I),
	.S_AXI_ARVALID_I (S_AXI_ARVALID_I),
	.S_AXI_ARREADY_O (S_AXI_ARREADY_O),
	.S_AXI_RDATA_O   (S_AXI_RDATA_O),
	.S_AXI_RVALID_O  (S_AXI_RVALID_O),
	.S_AXI_RREADY_I  (S_AXI_RREADY_I),
	.OUT_O           (OUT_O)
);

/* test/gate_bridge_model.sv */
/*
 * Bridge switches behind the gate drivers; counts shoot-through cycles.
 * Assumes outputs A, B share one leg and C, D the other, active high.
 */
`timescale 1ns/100ps
module gate_bridge_model
(
	// Clock.
	input  wire logic        clk_i,
	// Gate drive levels A to D.
	input  wire logic [3:0]  drive_i,
	// Cycles with both switches of a leg on.
	output logic      [15:0] overlap_cnt_o
);
	logic [3:0]  on_q  = 4'h0;  // Switches follow drive a cycle late.
	logic [15:0] cnt_q = 16'h0; // Cycles with a leg shorted.

	assign overlap_cnt_o = cnt_q;

	// A leg with both switches on shorts the supply.
	always @(posedge clk_i)
	begin
		on_q <= drive_i;
		if ((on_q[0] & on_q[1]) | (on_q[2] & on_q[3]))
			cnt_q <= cnt_q + 16'h1;
	end
endmodule

/* test/test_steering_deadband_waveform.sv */
/*
 * Self-checking bench: register bus tasks and output sequences.
 * Assumes the stage, its header and the bridge model are compiled.
 */
`timescale 1ns/100ps
`include "wg_cfg.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
	num_errors++; $display("unexpected at %0t: got %h exp %h", \
	$time, g, e); end end
module test_steering_deadband_waveform;
	logic        clk, nrst, awv, wv, bre, arv, rre, slp, shut;
	logic        tick = 1'b0;    // Fast oscillator tick.
	logic [7:0]  awa, ara;       // Bus addresses.
	logic [31:0] wd, rdv;        // Write data and last read data.
	logic [3:0]  ws;             // Write strobes.
	logic [15:0] src, ov0;       // Data sources and overlap snapshot.
	logic [1:0]  resp;           // Last response code.
	wire         awr, wrr, bv, arr, rv;
	wire  [1:0]  br, rr;
	wire  [31:0] rdat;
	wire  [3:0]  outp;
	wire  [15:0] ovc;
	int          num_errors, total_checks, k;
	logic [3:0]  pre [2] = '{4'h1, 4'h4};
	logic [3:0]  mid [2] = '{4'h4, 4'h1};
	logic [3:0]  fin [2] = '{4'h6, 4'h9};

	steering_deadband_waveform DUT (.CLK_I(clk), .NRST_I(nrst),
		.S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
		.S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(ws),
		.S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrr), .S_AXI_BRESP_O(br),
		.S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bre), .S_AXI_ARADDR_I(ara),
		.S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
		.S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv),
		.S_AXI_RREADY_I(rre), .DATA_SRC_I(src), .FAST_OSC_TICK_I(tick),
		.SLEEP_I(slp), .SHUTDOWN_I(shut), .OUT_O(outp));
	gate_bridge_model u_bridge (.clk_i(clk), .drive_i(outp),
		.overlap_cnt_o(ovc));

	// 40 MHz clock.
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Fast oscillator tick every other cycle, unrelated to the count.
	always @(posedge clk) tick <= ~tick;

	// Prints the counts and the verdict, then stops.
	task results();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Both write halves offered at once; each released when taken.
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic at, wt, bd;
		@(posedge clk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= 1'b1;
		bd = 1'b0;
		while (!bd)
		begin
			#1;
			at = awv & awr;
			wt = wv & wrr;
			bd = bv;
			resp = br;
			@(posedge clk);
			if (at) awv <= 1'b0;
			if (wt) wv <= 1'b0;
		end
		bre <= 1'b0;
	endtask

	// Read with ready held until the data is taken.
	task rd(input logic [7:0] a);
		logic at, dn;
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rre <= 1'b1;
		dn = 1'b0;
		while (!dn)
		begin
			#1;
			at = arv & arr;
			dn = rv;
			rdv = rdat;
			resp = rr;
			@(posedge clk);
			if (at) arv <= 1'b0;
		end
		rre <= 1'b0;
	endtask

	// Drives the sources at an edge.
	task sv(input logic [15:0] v);
		@(posedge clk);
		src <= v;
	endtask

	// Compares the outputs once the edge has settled.
	task ck(input logic [3:0] e);
		#1;
		`CHK(outp, e)
	endtask

	// Main sequence.
	initial
	begin
		{nrst, awv, wv, bre, arv, rre, slp, shut} = 8'h00;
		{awa, ara, wd, src} = '0;
		ws = 4'hF;
		num_errors = 0;
		total_checks = 0;
		cyc(4);
		nrst <= 1'b1;
		rd(`WG_OFF_CTRL);
		`CHK(rdv, 32'h0)
		wr(8'h40, 32'h0);
		`CHK(resp, `WG_RESP_ERR)
		rd(8'h40);
		`CHK(resp, `WG_RESP_ERR)
		// Asynchronous steering of output A, others held.
		wr(`WG_OFF_POL, 32'hF);
		wr(`WG_OFF_STEER, 32'hE1);
		wr(`WG_OFF_CTRL, 32'h80);
		for (k = 0; k < 16; k++)
		begin
			wr(`WG_OFF_ISRC, k);
			sv(16'h1 << k);
			cyc(3);
			ck(4'hF);
			sv(~(16'h1 << k));
			cyc(3);
			ck(4'hE);
		end
		sv(16'hFFFF);
		wr(`WG_OFF_POL, 32'h0);
		cyc(2);
		ck(4'hE);
		wr(`WG_OFF_POL, 32'hF);
		wr(`WG_OFF_SHUT, 32'h0);
		@(posedge clk);
		shut <= 1'b1;
		cyc(3);
		ck(4'hE);
		@(posedge clk);
		shut <= 1'b0;
		cyc(3);
		ck(4'hF);
		wr(`WG_OFF_STEER, 32'hE0);
		cyc(2);
		ck(4'hE);
		// Synchronous steering waits for the next input rise.
		sv(16'h0);
		wr(`WG_OFF_CTRL, 32'h0);
		wr(`WG_OFF_STEER, 32'h0);
		wr(`WG_OFF_CTRL, 32'h81);
		sv(16'hFFFF);
		wr(`WG_OFF_STEER, 32'h01);
		cyc(3);
		ck(4'h0);
		wr(`WG_OFF_STEER, 32'h21);
		cyc(3);
		ck(4'h2);
		sv(16'h0);
		sv(16'hFFFF);
		cyc(3);
		ck(4'h3);
		// Half bridge with rise count 4 and fall count 2.
		sv(16'h0);
		wr(`WG_OFF_CTRL, 32'h04);
		wr(`WG_OFF_DBR, 32'h4);
		wr(`WG_OFF_DBF, 32'h2);
		wr(`WG_OFF_CTRL, 32'h84);
		cyc(6);
		ck(4'hA);
		ov0 = ovc;
		sv(16'hFFFF);
		cyc(4);
		ck(4'h0);
		cyc(4);
		ck(4'h5);
		sv(16'h0);
		cyc(3);
		ck(4'h0);
		cyc(4);
		ck(4'hA);
		wr(`WG_OFF_CTRL, 32'h04);
		wr(`WG_OFF_DBR, 32'h0);
		wr(`WG_OFF_CTRL, 32'h84);
		sv(16'hFFFF);
		cyc(4);
		ck(4'h5);
		// Short pulse against a long count leaves A off.
		sv(16'h0);
		wr(`WG_OFF_CTRL, 32'h04);
		wr(`WG_OFF_DBR, 32'h8);
		wr(`WG_OFF_CTRL, 32'h84);
		sv(16'hFFFF);
		cyc(3);
		sv(16'h0);
		repeat (12)
		begin
			cyc(1);
			#1;
			`CHK(outp[0], 1'b0)
		end
		// Load request while running: count 1 lands after fall then rise.
		wr(`WG_OFF_DBR, 32'h1);
		wr(`WG_OFF_CTRL, 32'hC4);
		sv(16'hFFFF);
		cyc(20);
		sv(16'h0);
		cyc(6);
		rd(`WG_OFF_CTRL);
		`CHK(rdv[6], 1'b1)
		sv(16'hFFFF);
		cyc(14);
		rd(`WG_OFF_CTRL);
		`CHK(rdv[6], 1'b0)
		sv(16'h0);
		cyc(8);
		sv(16'hFFFF);
		cyc(6);
		ck(4'h5);
		`CHK(ovc - ov0, 16'h0)
		// Sleep stalls the system clock count but not the oscillator.
		sv(16'h0);
		wr(`WG_OFF_CTRL, 32'h04);
		wr(`WG_OFF_DBR, 32'h2);
		wr(`WG_OFF_CTRL, 32'h84);
		slp <= 1'b1;
		sv(16'hFFFF);
		cyc(14);
		ck(4'h0);
		sv(16'h0);
		wr(`WG_OFF_CLK, 32'h1);
		sv(16'hFFFF);
		cyc(14);
		ck(4'h5);
		@(posedge clk);
		slp <= 1'b0;
		wr(`WG_OFF_CLK, 32'h0);
		// Full bridge, forward then both direction changes.
		sv(16'h0);
		wr(`WG_OFF_CTRL, 32'h02);
		wr(`WG_OFF_DBR, 32'h3);
		wr(`WG_OFF_DBF, 32'h3);
		wr(`WG_OFF_CTRL, 32'h82);
		cyc(4);
		ck(4'h1);
		sv(16'hFFFF);
		cyc(4);
		ck(4'h9);
		sv(16'h0);
		cyc(3);
		for (k = 0; k < 2; k++)
		begin
			wr(`WG_OFF_CTRL, (k == 0) ? 32'h83 : 32'h82);
			cyc(3);
			ck(pre[k]);
			sv(16'hFFFF);
			cyc(4);
			ck(mid[k]);
			cyc(5);
			ck(fin[k]);
			sv(16'h0);
			cyc(3);
		end
		// Push-pull sequencing is not built: outputs rest inactive.
		wr(`WG_OFF_POL, 32'h5);
		wr(`WG_OFF_CTRL, 32'h85);
		cyc(2);
		ck(4'hA);
		results();
	end

	// Cuts a hang short.
	initial
	begin
		repeat (20000) @(posedge clk);
		num_errors++;
		results();
	end
endmodule
